// File: rtl/liusi_defs.svh
// register offsets, field positions, reset values and timing figures of the
// line status interrupt block; assumes a 200 MHz system clock
`ifndef LIUSI_DEFS_SVH
`define LIUSI_DEFS_SVH

// ============================================================
// register byte offsets (32-bit aligned words)
`define LIUSI_OFS_STATUS     8'h00
`define LIUSI_OFS_INT_STAT   8'h04
`define LIUSI_OFS_INT_MASK   8'h08
`define LIUSI_OFS_EDGE_SEL   8'h0C
`define LIUSI_OFS_CONTROL    8'h10

// ============================================================
// field positions in status, sticky, mask and edge registers
`define LIUSI_BIT_DEACT      5
`define LIUSI_BIT_PATTERN    4
`define LIUSI_BIT_TXLOSS     3
// control register fields
`define LIUSI_BIT_AUTO_LOOP  0
`define LIUSI_BIT_REM_LOOP   1

// ============================================================
// reset values
`define LIUSI_RST_MASK       32'h0000_0038
`define LIUSI_RST_EDGE       32'h0000_0000
`define LIUSI_RST_CONTROL    32'h0000_0000

// ============================================================
// timing: clock rate and qualification times
`define LIUSI_CLK_KHZ        200000
`define LIUSI_QUAL_OFF_MS    40
`define LIUSI_QUAL_ON_MS     5100
`define LIUSI_TXLOSS_MCLKS   70
// error-rate window: qualifying needs fewer than this many errors per window of bits; a set status holds up to this many
`define LIUSI_BER_WIN_BITS   1000
`define LIUSI_BER_ERR_LIMIT  10

`endif

// File: rtl/liusi_pkg.sv
// types shared by the line status interrupt block
// assumes nothing beyond a SystemVerilog compiler
package liusi_pkg;

	// ============================================================
	// deactivate-code qualifier states
	typedef enum logic [1:0] {
		LIUSI_Q_IDLE = 2'b00,
		LIUSI_Q_QUAL = 2'b01,
		LIUSI_Q_SET  = 2'b10
	} liusi_qual_e;

	// three status bits carried as one vector, msb = deactivate
	typedef logic [2:0] liusi_vec_t;

endpackage

// File: rtl/liusi_evt_if.sv
// carrier between the status core and its edge-select event detector
// assumes both ends run on the same clock
`timescale 1ns/1ps

interface liusi_evt_if;
	import liusi_pkg::*;
	liusi_vec_t status;   // real-time status bits
	liusi_vec_t edge_sel; // 0: rising only, 1: any change
	liusi_vec_t event_p;  // one-cycle event pulses

	modport core (output status, output edge_sel, input event_p);
	modport det  (input status, input edge_sel, output event_p);
endinterface

// File: rtl/liusi_edge_det.sv
// edge-select event detector, one slice per status bit
// assumes status bits come from flops on the same clock
`timescale 1ns/1ps

module liusi_edge_det
	import liusi_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	liusi_evt_if.det  evt
);

	liusi_vec_t prev_q;
	liusi_vec_t event_q;

	assign evt.event_p = event_q;

	// ============================================================
	// per-bit edge detection
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_bit
			// rising always counts, falling only when edge select is set
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					prev_q[gi]  <= 1'b0;
					event_q[gi] <= 1'b0;
				end else begin
					prev_q[gi]  <= evt.status[gi];
					event_q[gi] <= (evt.status[gi] & ~prev_q[gi])
						| (evt.edge_sel[gi] & ~evt.status[gi] & prev_q[gi]);
				end
			end
		end
	endgenerate

endmodule // liusi_edge_det

// File: rtl/liusi_clk_loss.sv
// transmit clock loss monitor counted in master clock cycles
// assumes both pins are asynchronous to clk and much slower than it
`timescale 1ns/1ps
`include "liusi_defs.svh"

module liusi_clk_loss #(
	parameter logic [7:0] LOSS_MCLKS = 8'(`LIUSI_TXLOSS_MCLKS)
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic tx_line_clock,
	input  wire logic master_clock,
	output logic      loss
);

	logic [2:0] tx_sync_q;
	logic [2:0] mc_sync_q;
	logic [7:0] cnt_q;
	logic       loss_q;

	assign loss = loss_q;

	// ============================================================
	// two-flop synchronisers, third flop only for edge detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_sync_q <= 3'h0;
			mc_sync_q <= 3'h0;
		end else begin
			tx_sync_q <= {tx_sync_q[1:0], tx_line_clock};
			mc_sync_q <= {mc_sync_q[1:0], master_clock};
		end
	end

	// count master clock rises since the last transmit clock toggle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= 8'h00;
			loss_q <= 1'b0;
		end else begin
			if (tx_sync_q[2] != tx_sync_q[1]) begin
				cnt_q  <= 8'h00;
				loss_q <= 1'b0;
			end else if (mc_sync_q[2] == 1'b0 && mc_sync_q[1] == 1'b1) begin
				// saturate so a dead clock cannot wrap back to normal
				if (cnt_q != 8'hFF)
					cnt_q <= cnt_q + 8'h01;
				if (cnt_q >= LOSS_MCLKS)
					loss_q <= 1'b1;
			end
		end
	end

endmodule // liusi_clk_loss

// File: rtl/liusi_top.sv
// line status interrupt block: loopback deactivate qualifier, pattern sync
// and transmit clock loss status with edge-select interrupts
// assumes an Avalon-MM master on clk and a datapath on the same clock
//
// What this block does
// - deactivate bit 5 set after qualified code
// - bit holds while window errors stay at or under limit, clears above it
// - qualify 40 ms, or 5.1 s with auto switch
// - deactivate rising edge ends remote loopback
// - deactivate interrupt: rise, or any change if selected
// - bit 4 mirrors pattern sync in real time
// - pattern interrupt: rise, or any change if selected
// - bit 3 set after 70 idle master clocks
`timescale 1ns/1ps
`include "liusi_defs.svh"

module liusi_top
	import liusi_pkg::*;
#(
	parameter int unsigned QUAL_OFF_CYC = `LIUSI_QUAL_OFF_MS * `LIUSI_CLK_KHZ,
	parameter int unsigned QUAL_ON_CYC  = `LIUSI_QUAL_ON_MS * `LIUSI_CLK_KHZ,
	parameter int unsigned BER_WIN      = `LIUSI_BER_WIN_BITS,
	parameter int unsigned BER_LIMIT    = `LIUSI_BER_ERR_LIMIT
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        deact_code_detect,
	input  wire logic        deact_bit_valid,
	input  wire logic        deact_bit_error,
	input  wire logic        pattern_sync_in,
	input  wire logic        tx_line_clock,
	input  wire logic        master_clock,
	output logic             irq,
	output logic             remote_loop_active,
	output logic             loopback_deact_status
);

	// ============================================================
	// declarations
	// bus, configuration and status registers first, then qualifier state
	liusi_evt_if evt ();

	logic [31:0] readdata_q;
	logic        wait_q;
	logic [31:0] sticky_q;
	logic [31:0] sticky_d;
	logic [31:0] mask_q;
	logic [31:0] edge_q;
	logic [31:0] ctrl_q;
	logic [31:0] status_w;
	logic        irq_q;
	logic        deact_q;
	logic        deact_prev_q;
	logic        pattern_q;
	logic        txloss_w;
	logic        remloop_q;
	liusi_qual_e qst_q;
	logic [31:0] timer_q;
	logic [31:0] qual_cyc;
	logic [15:0] bit_cnt_q;
	logic [15:0] err_cnt_q;
	logic        win_end;
	logic        err_ok;
	logic        err_exceed;
	logic        req;
	logic        take;
	logic        wr_take;

	// every output port is a flop, never a gate
	assign avs_readdata          = readdata_q;
	assign avs_waitrequest       = wait_q;
	assign irq                   = irq_q;
	assign remote_loop_active    = remloop_q;
	assign loopback_deact_status = deact_q;

	// ============================================================
	// bus handshake
	// every access takes exactly one wait cycle: request seen at edge 1,
	// waitrequest low during the next cycle, taken at edge 2
	// the fixed wait lets read data come from a flop instead of a mux
	// on the port; the cost is one extra cycle per access
	// a master that drops its request early simply never sees the take
	assign req     = avs_read | avs_write;
	assign take    = req & ~wait_q;
	assign wr_take = take & avs_write;

	// waitrequest is high at rest and drops for the single answer cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			wait_q <= 1'b1;
		else
			wait_q <= ~(req & wait_q);
	end

	// read data latched one cycle ahead so it stands when waitrequest drops
	// the word is captured once per access, so a status bit that moves
	// during the wait cycle shows up on the next read instead
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata_q <= 32'h0000_0000;
		end else if (avs_read && wait_q) begin
			case (avs_address)
				`LIUSI_OFS_STATUS:   readdata_q <= status_w;
				`LIUSI_OFS_INT_STAT: readdata_q <= sticky_q;
				`LIUSI_OFS_INT_MASK: readdata_q <= mask_q;
				`LIUSI_OFS_EDGE_SEL: readdata_q <= edge_q;
				`LIUSI_OFS_CONTROL:  readdata_q <= {ctrl_q[31:2], remloop_q, ctrl_q[0]};
				default:             readdata_q <= 32'h0000_0000; // unmapped reads zero
			endcase
		end
	end

	// ============================================================
	// software-written configuration
	// only the three status positions exist; other bits stay zero
	// mask resets to ones in all three status positions so nothing interrupts before software is ready
	// writes to the status word or unmapped offsets fall through unused
	// control keeps only the auto switch; the loop enable has its own flop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_q <= `LIUSI_RST_MASK;
			edge_q <= `LIUSI_RST_EDGE;
			ctrl_q <= `LIUSI_RST_CONTROL;
		end else if (wr_take) begin
			case (avs_address)
				`LIUSI_OFS_INT_MASK: mask_q <= avs_writedata & `LIUSI_RST_MASK;
				`LIUSI_OFS_EDGE_SEL: edge_q <= avs_writedata & `LIUSI_RST_MASK;
				`LIUSI_OFS_CONTROL:  ctrl_q <= {31'h0, avs_writedata[`LIUSI_BIT_AUTO_LOOP]};
				default:             ;
			endcase
		end
	end

	// ============================================================
	// remote loopback enable
	// the deactivate rising edge wins over a same-cycle software set,
	// so a far end that is tearing the loop down is never overridden
	// software may set the loop again later; a new rise or a software write of zero clears it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			remloop_q <= 1'b0;
		end else if (deact_q && !deact_prev_q) begin
			remloop_q <= 1'b0;
		end else if (wr_take && avs_address == `LIUSI_OFS_CONTROL) begin
			remloop_q <= avs_writedata[`LIUSI_BIT_REM_LOOP];
		end
	end

	// ============================================================
	// error-rate window over received code bits
	// errors are judged in fixed windows; a window restarts on exit to idle
	// the window closes on the bit after the last one, so the count of a
	// full window stays visible to the qualifier until the next bit comes
	assign win_end    = deact_bit_valid && (bit_cnt_q == 16'(BER_WIN));
	assign err_ok     = err_cnt_q < 16'(BER_LIMIT);
	assign err_exceed = err_cnt_q > 16'(BER_LIMIT);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_cnt_q <= 16'h0000;
			err_cnt_q <= 16'h0000;
		end else if (qst_q == LIUSI_Q_IDLE) begin
			bit_cnt_q <= 16'h0000;
			err_cnt_q <= 16'h0000;
		end else if (win_end) begin
			// the closing bit opens the next window, so no bit goes unjudged
			bit_cnt_q <= 16'h0001;
			err_cnt_q <= {15'h0000, deact_bit_error};
		end else if (deact_bit_valid) begin
			bit_cnt_q <= bit_cnt_q + 16'h0001;
			if (deact_bit_error && err_cnt_q != 16'hFFFF)
				err_cnt_q <= err_cnt_q + 16'h0001;
		end
	end

	// ============================================================
	// deactivate code qualifier
	// qualifying time depends on automatic remote loopback switching
	// the 32-bit timer covers the long setting at the full clock rate
	// a change of the switch during qualification applies the new limit
	// to the running count rather than starting over
	assign qual_cyc = ctrl_q[`LIUSI_BIT_AUTO_LOOP] ? QUAL_ON_CYC : QUAL_OFF_CYC;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			qst_q   <= LIUSI_Q_IDLE;
			timer_q <= 32'h0000_0000;
		end else begin
			case (qst_q)
				LIUSI_Q_IDLE: begin
					// timer held at zero so each attempt starts from a fresh count
					timer_q <= 32'h0000_0000;
					if (deact_code_detect)
						qst_q <= LIUSI_Q_QUAL;
				end
				LIUSI_Q_QUAL: begin
					// strictly longer than t: leave only once timer passes it
					// a gap or too many errors restarts the whole qualification
					if (!deact_code_detect || !err_ok) begin
						qst_q <= LIUSI_Q_IDLE;
					end else if (timer_q > qual_cyc) begin
						qst_q <= LIUSI_Q_SET;
					end else begin
						timer_q <= timer_q + 32'h0000_0001;
					end
				end
				LIUSI_Q_SET: begin
					// a window over the limit or a gap in the code ends the status
					if (!deact_code_detect || err_exceed)
						qst_q <= LIUSI_Q_IDLE;
				end
				default: qst_q <= LIUSI_Q_IDLE;
			endcase
		end
	end

	// status flops; deactivate follows the qualifier state
	// pattern sync comes from logic on this clock, so one flop is enough;
	// the flop keeps every output and event a plain register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			deact_q      <= 1'b0;
			deact_prev_q <= 1'b0;
			pattern_q    <= 1'b0;
		end else begin
			deact_q      <= (qst_q == LIUSI_Q_SET);
			deact_prev_q <= deact_q;
			pattern_q    <= pattern_sync_in;
		end
	end

	// ============================================================
	// transmit clock loss monitor
	// both pins are synchronised inside; the limit is its default count of
	// master clocks, counted only while no transmit edge arrives
	liusi_clk_loss u_clk_loss (
		.clk           (clk),
		.rst_n         (rst_n),
		.tx_line_clock (tx_line_clock),
		.master_clock  (master_clock),
		.loss          (txloss_w)
	);

	// real-time status word
	// unused positions read zero so software may test the word whole
	always_comb begin
		status_w                    = 32'h0000_0000;
		status_w[`LIUSI_BIT_DEACT]   = deact_q;
		status_w[`LIUSI_BIT_PATTERN] = pattern_q;
		status_w[`LIUSI_BIT_TXLOSS]  = txloss_w;
	end

	// ============================================================
	// edge-select event detection
	// order in the carrier is deactivate, pattern, clock loss (msb first)
	// events are counted from the same flops that software reads
	assign evt.status   = {deact_q, pattern_q, txloss_w};
	assign evt.edge_sel = {edge_q[`LIUSI_BIT_DEACT], edge_q[`LIUSI_BIT_PATTERN],
		edge_q[`LIUSI_BIT_TXLOSS]};

	liusi_edge_det u_edge_det (
		.clk   (clk),
		.rst_n (rst_n),
		.evt   (evt.det)
	);

	// ============================================================
	// sticky interrupt status, write one to clear
	// a new event in the clearing cycle is kept: set wins over clear
	// events latch even while masked, so unmasking later shows history
	always_comb begin
		sticky_d = sticky_q;
		if (wr_take && avs_address == `LIUSI_OFS_INT_STAT)
			sticky_d = sticky_q & ~avs_writedata;
		sticky_d[`LIUSI_BIT_DEACT]   = sticky_d[`LIUSI_BIT_DEACT] | evt.event_p[2];
		sticky_d[`LIUSI_BIT_PATTERN] = sticky_d[`LIUSI_BIT_PATTERN] | evt.event_p[1];
		sticky_d[`LIUSI_BIT_TXLOSS]  = sticky_d[`LIUSI_BIT_TXLOSS] | evt.event_p[0];
	end

	// sticky register; its next value is built above
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			sticky_q <= 32'h0000_0000;
		else
			sticky_q <= sticky_d;
	end

	// mask bit at zero lets the sticky bit reach the interrupt line
	// a register here keeps the pin glitch free at the cost of one cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			irq_q <= 1'b0;
		else
			irq_q <= |(sticky_q & ~mask_q);
	end

endmodule // liusi_top

// File: verif/liusi_top_sva.sv
// checker for the line status interrupt block, bound to its top module
// assumes one clock domain and the top module's port names
`timescale 1ns/1ps

module liusi_top_sva #(
	parameter int unsigned QUAL_OFF_CYC = 50
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [7:0]  avs_address,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        deact_code_detect,
	input wire logic        remote_loop_active,
	input wire logic        loopback_deact_status
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// helper: run length of the deactivate code, zero on any gap
	logic [31:0] det_run_q;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			det_run_q <= 32'h0;
		else if (!deact_code_detect)
			det_run_q <= 32'h0;
		else
			det_run_q <= det_run_q + 32'h1;
	end

	// ==========================================================
	// bus access shape: one wait cycle, then back to waiting
	sequence s_one_wait;
		avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
	endsequence

	a_wait_single: assert property ($rose(avs_read || avs_write) |-> s_one_wait)
		else $error("access did not take exactly one wait cycle");
	a_wait_owned: assert property (!avs_waitrequest |-> (avs_read || avs_write))
		else $error("waitrequest low without a request");
	a_rdata_hold: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
		else $error("read data changed outside a read");
	a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 8'h10
		|-> avs_readdata == 32'h0)
		else $error("unmapped read returned nonzero");
	a_status_fields: assert property (avs_read && !avs_waitrequest && avs_address == 8'h00
		|-> avs_readdata[31:6] == 26'h0 && avs_readdata[2:0] == 3'h0)
		else $error("status word has bits outside 5..3");
	a_remote_by_write: assert property ($rose(remote_loop_active)
		|-> $past(avs_write && !avs_waitrequest && avs_address == 8'h10))
		else $error("remote loop rose without a control write");
	a_deact_qual: assert property ($rose(loopback_deact_status)
		|-> det_run_q > QUAL_OFF_CYC)
		else $error("deactivate status set before qualification");
	a_deact_drop: assert property ($fell(deact_code_detect)
		|-> ##[0:2] !loopback_deact_status)
		else $error("deactivate status outlived the code");
	a_loop_ended: assert property ($rose(loopback_deact_status)
		|-> ##[0:1] !remote_loop_active)
		else $error("remote loop survived deactivate rise");
endmodule // liusi_top_sva

bind liusi_top liusi_top_sva #(.QUAL_OFF_CYC(QUAL_OFF_CYC)) i_sva (
	.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.deact_code_detect(deact_code_detect), .remote_loop_active(remote_loop_active),
	.loopback_deact_status(loopback_deact_status));

// File: verif/liusi_line_model.sv
// line side model: master clock, transmit clock and received code bits
// assumes clk is the 200 MHz system clock; clocks are slow against it
`timescale 1ns/1ps

module liusi_line_model (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic tx_stop,
	input  wire logic err_on,
	output logic      master_clock,
	output logic      tx_line_clock,
	output logic      deact_bit_valid,
	output logic      deact_bit_error
);
	logic [2:0] div_q;
	logic       tx_q;

	// ==========================================================
	// divider: master clock at clk/8, one code bit every 4 cycles
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			div_q <= 3'h0;
		else
			div_q <= div_q + 3'h1;
	end

	// transmit clock freezes at its last level when stopped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			tx_q <= 1'h0;
		else if (!tx_stop && div_q[1:0] == 2'h1)
			tx_q <= ~tx_q;
	end

	assign master_clock    = div_q[2];
	assign tx_line_clock   = tx_q;
	assign deact_bit_valid = (div_q[1:0] == 2'h0);
	assign deact_bit_error = deact_bit_valid & err_on; // every bit bad when on
endmodule // liusi_line_model

// File: verif/liusi_top_test.sv
// self-checking bench for the line status interrupt block
// assumes the line model and checker files are compiled before it
`timescale 1ns/1ps

module liusi_top_test;
	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic [7:0]  avs_address = 8'h00;
	logic        avs_read = 1'h0;
	logic        avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, rd_q;
	logic        avs_waitrequest, irq, remote_loop_active, loopback_deact_status;
	logic        deact_code_detect = 1'h0;
	logic        pattern_sync_in = 1'h0;
	logic        tx_stop = 1'h0;
	logic        err_on = 1'h0;
	logic        master_clock, tx_line_clock, deact_bit_valid, deact_bit_error;
	int          num_errors = 0;
	int          comparisons = 0;

	always #2.5 clk = ~clk;

	// short qualification counts keep the run brief
	liusi_top #(.QUAL_OFF_CYC(50), .QUAL_ON_CYC(200), .BER_WIN(20), .BER_LIMIT(2)) i_dut (
		.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .deact_code_detect(deact_code_detect),
		.deact_bit_valid(deact_bit_valid), .deact_bit_error(deact_bit_error),
		.pattern_sync_in(pattern_sync_in), .tx_line_clock(tx_line_clock),
		.master_clock(master_clock), .irq(irq), .remote_loop_active(remote_loop_active),
		.loopback_deact_status(loopback_deact_status));

	liusi_line_model i_line (
		.clk(clk), .rst_n(rst_n), .tx_stop(tx_stop), .err_on(err_on),
		.master_clock(master_clock), .tx_line_clock(tx_line_clock),
		.deact_bit_valid(deact_bit_valid), .deact_bit_error(deact_bit_error));

	// ==========================================================
	// one bus access; held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		// only the watchdog ends a wait that never sees an answer
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'h0);
		rd_q = avs_readdata;
		avs_read  <= 1'h0;
		avs_write <= 1'h0;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// raise or drop the condition behind status bit b
	task automatic cond(input int b, input logic v);
		@(posedge clk);
		if (b == 5)
			deact_code_detect <= v;
		else if (b == 4)
			pattern_sync_in <= v;
		else
			tx_stop <= v;
	endtask

	task automatic final_report;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ==========================================================
	// watchdog well beyond the roughly 3000 cycles the tests need
	initial begin
		repeat (40000) @(posedge clk);
		num_errors++;
		final_report();
	end

	initial begin
		logic [7:0]  ra [6];
		logic [31:0] rv [6];
		int          q;
		ra = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
		rv = '{32'h0, 32'h0, 32'h38, 32'h0, 32'h0, 32'h0};
		repeat (20) @(posedge clk);
		rst_n <= 1'h1;
		// reset values, read-only status and an unmapped place
		bus(1'h1, 8'h00, 32'h38);
		bus(1'h1, 8'h20, 32'hFFFF_FFFF);
		for (int i = 0; i < 6; i++) begin
			bus(1'h0, ra[i], 32'h0);
			check(rd_q, rv[i]);
		end
		check(32'(irq), 32'h0);
		// each bit, each edge select; masked when es is 0
		for (int b = 3; b <= 5; b++) begin
			for (int es = 0; es < 2; es++) begin
				q = (b == 5) ? (es != 0 ? 200 : 50) : (b == 3 ? 500 : 0);
				bus(1'h1, 8'h08, es != 0 ? 32'h0 : 32'h38);
				bus(1'h1, 8'h0C, 32'(es) << b);
				bus(1'h1, 8'h10, (b == 5) ? (32'h2 | 32'(es)) : 32'h0);
				// the control write lands at the edge that ends the access
				@(posedge clk);
				check(32'(remote_loop_active), (b == 5) ? 32'h1 : 32'h0);
				cond(b, 1'h1);
				if (q > 0) begin
					repeat (q * 4 / 5) @(posedge clk);
					bus(1'h0, 8'h00, 32'h0);
					check(rd_q, 32'h0);
				end
				repeat (q + 5) @(posedge clk);
				bus(1'h0, 8'h00, 32'h0);
				check(rd_q, 32'h1 << b);
				check(32'(irq), 32'(es));
				bus(1'h0, 8'h04, 32'h0);
				check(rd_q, 32'h1 << b);
				if (b == 5)
					check(32'(remote_loop_active), 32'h0);
				bus(1'h1, 8'h04, 32'h38);
				repeat (2) @(posedge clk);
				check(32'(irq), 32'h0);
				cond(b, 1'h0);
				repeat (10) @(posedge clk);
				bus(1'h0, 8'h04, 32'h0);
				check(rd_q, 32'(es) << b);
				check(32'(irq), 32'(es));
				bus(1'h1, 8'h04, 32'h38);
			end
		end
		// qualified code holds through clean windows, drops on errors
		bus(1'h1, 8'h10, 32'h0);
		cond(5, 1'h1);
		repeat (250) @(posedge clk);
		check(32'(loopback_deact_status), 32'h1);
		@(posedge clk);
		err_on <= 1'h1;
		repeat (200) @(posedge clk);
		check(32'(loopback_deact_status), 32'h0);
		final_report();
	end
endmodule // liusi_top_test
